//--- design/pcg_map.vh
// register map and field layout of the peripheral clock gating block
// assumes a 32-bit bus with one aligned word per register index
`ifndef PCG_MAP_VH
`define PCG_MAP_VH

// register indices, byte address is four times the index
`define PCG_IDX_CTRL0     8'h64
`define PCG_IDX_CTRL1     8'h65
`define PCG_IDX_STAT0     8'h66
`define PCG_IDX_STAT1     8'h67

// writable bits of each control register, reserved bits stay zero
`define PCG_CTRL0_MASK    8'hEF
`define PCG_CTRL1_MASK    8'h3F
`define PCG_CTRL_RESET    8'h00

// field positions in the first control register
`define PCG_B0_TWO_WIRE   7
`define PCG_B0_TIMER_2    6
`define PCG_B0_TIMER_0    5
`define PCG_B0_TIMER_1    3
`define PCG_B0_SERIAL     2
`define PCG_B0_UART_0     1
`define PCG_B0_CONVERTER  0

// field positions in the second control register
`define PCG_B1_TIMER_5    5
`define PCG_B1_TIMER_4    4
`define PCG_B1_TIMER_3    3
`define PCG_B1_UART_3     2
`define PCG_B1_UART_2     1
`define PCG_B1_UART_1     0

// peripheral slots in the gate vector
`define PCG_NUM_PERIPH    13
`define PCG_P_CONVERTER   0
`define PCG_P_UART_0      1
`define PCG_P_SERIAL      2
`define PCG_P_TIMER_1     3
`define PCG_P_TIMER_0     4
`define PCG_P_TIMER_2     5
`define PCG_P_TWO_WIRE    6
`define PCG_P_UART_1      7
`define PCG_P_UART_2      8
`define PCG_P_UART_3      9
`define PCG_P_TIMER_3     10
`define PCG_P_TIMER_4     11
`define PCG_P_TIMER_5     12

// bus constants
`define PCG_HTRANS_NONSEQ 2'h2
`define PCG_HRESP_OKAY    1'h0
`endif

//--- design/pcg_top.v
// peripheral clock gating: two gating registers on an ahb-lite slave,
// one glitch-free clock gate and one access blocker per peripheral
// assumes every port is on mclk_i; peripherals run on the gated clocks
`timescale 1ns/1ps
`default_nettype none
`include "pcg_map.vh"

// What this block does
// - a gated peripheral keeps frozen state and its register access is blocked
// - clearing a gate bit restarts the clock, peripheral resumes unchanged
// - gating acts in active and idle; deeper sleep already stops clocks
// - first register bit 7 gates the two-wire interface; reinit afterwards
// - first register bit 6 gates timer 2 only when not asynchronous
// - first register bits 5 and 3 gate timers 0 and 1
// - first register bit 4 is reserved, ignores writes, reads zero
// - first register bit 2 gates the serial peripheral interface
// - first register bit 1 gates uart 0; reinit afterwards
// - first register bit 0 gates the converter; disable it beforehand
// - second register bits 7 and 6 reserved, ignore writes, read zero
// - second register bits 5, 4, 3 gate timers 5, 4, 3
// - second register bits 2, 1, 0 gate uarts 3, 2, 1
module pcg_top (
   // clock and reset
   input  wire        mclk_i,
   input  wire        rstn_i,
   // ahb-lite slave
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire        hready_i,
   input  wire [31:0] hwdata_i,
   output wire        hreadyout_o,
   output wire        hresp_o,
   output reg  [31:0] hrdata_o,
   // system state
   input  wire        clk_io_run_i,
   input  wire        timer2_async_select_i,
   // register access requests from the cpu to each peripheral
   input  wire [12:0] periph_access_i,
   output wire [12:0] periph_access_o,
   // gated peripheral clocks
   output wire        clk_converter_o,
   output wire        clk_uart_0_o,
   output wire        clk_serial_periph_o,
   output wire        clk_timer_1_o,
   output wire        clk_timer_0_o,
   output wire        clk_timer_2_o,
   output wire        clk_two_wire_o,
   output wire        clk_uart_1_o,
   output wire        clk_uart_2_o,
   output wire        clk_uart_3_o,
   output wire        clk_timer_3_o,
   output wire        clk_timer_4_o,
   output wire        clk_timer_5_o
);

   // software registers
   reg  [7:0]  clock_gate_ctrl_0;
   reg  [7:0]  clock_gate_ctrl_1;
   // data phase bookkeeping
   reg         dp_write;
   reg  [7:0]  dp_index;
   // applied gate state and sleep flag, both moved on the falling edge
   wire [12:0] gate_q;
   reg         run_q;
   // combinational helpers
   wire        addr_take;
   wire [12:0] gate_req;
   reg  [7:0]  next_rdata;

   // word index of an address; upper bits must be zero to hit
   function [8:0] pcg_index;
      input [31:0] addr;
      begin
         if (addr[31:10] == 22'h000000) begin
            pcg_index = {1'b1, addr[9:2]};
         end else begin
            pcg_index = 9'h000;
         end
      end
   endfunction

   // true when the address hits the given register index
   function pcg_hit;
      input [31:0] addr;
      input [7:0]  idx;
      reg   [8:0]  dec;
      begin
         dec = pcg_index(addr);
         pcg_hit = dec[8] && (dec[7:0] == idx);
      end
   endfunction

   // map the two registers onto the peripheral slot order
   function [12:0] pcg_gate_vec;
      input [7:0] r0;
      input [7:0] r1;
      input       t2_async;
      reg   [12:0] v;
      begin
         v = 13'h0000;
         v[`PCG_P_CONVERTER] = r0[`PCG_B0_CONVERTER];
         v[`PCG_P_UART_0]    = r0[`PCG_B0_UART_0];
         v[`PCG_P_SERIAL]    = r0[`PCG_B0_SERIAL];
         v[`PCG_P_TIMER_1]   = r0[`PCG_B0_TIMER_1];
         v[`PCG_P_TIMER_0]   = r0[`PCG_B0_TIMER_0];
         // async timer 2 keeps its own clock, so the bit has no hold there
         v[`PCG_P_TIMER_2]   = r0[`PCG_B0_TIMER_2] & ~t2_async;
         v[`PCG_P_TWO_WIRE]  = r0[`PCG_B0_TWO_WIRE];
         v[`PCG_P_UART_1]    = r1[`PCG_B1_UART_1];
         v[`PCG_P_UART_2]    = r1[`PCG_B1_UART_2];
         v[`PCG_P_UART_3]    = r1[`PCG_B1_UART_3];
         v[`PCG_P_TIMER_3]   = r1[`PCG_B1_TIMER_3];
         v[`PCG_P_TIMER_4]   = r1[`PCG_B1_TIMER_4];
         v[`PCG_P_TIMER_5]   = r1[`PCG_B1_TIMER_5];
         pcg_gate_vec = v;
      end
   endfunction

   // zero wait states, every transfer answers okay
   assign hreadyout_o = 1'b1;
   assign hresp_o     = `PCG_HRESP_OKAY;

   // an address phase is taken when selected, nonseq and ready
   assign addr_take = hsel_i && (htrans_i == `PCG_HTRANS_NONSEQ) &&
                      hready_i;

   // capture the address phase for the following data phase
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dp_write <= 1'b0;
         dp_index <= 8'h00;
      end else if (addr_take) begin
         dp_write <= hwrite_i && pcg_index(haddr_i) != 9'h000;
         dp_index <= haddr_i[9:2];
      end else begin
         dp_write <= 1'b0;
      end
   end

   // write in the data phase; reserved bits are masked off
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clock_gate_ctrl_0 <= `PCG_CTRL_RESET;
         clock_gate_ctrl_1 <= `PCG_CTRL_RESET;
      end else if (dp_write) begin
         if (dp_index == `PCG_IDX_CTRL0) begin
            clock_gate_ctrl_0 <= hwdata_i[7:0] & `PCG_CTRL0_MASK;
         end
         if (dp_index == `PCG_IDX_CTRL1) begin
            clock_gate_ctrl_1 <= hwdata_i[7:0] & `PCG_CTRL1_MASK;
         end
      end
   end

   // read mux, looked up in the address phase so data is ready next cycle
   always @* begin
      next_rdata = 8'h00;
      if (pcg_hit(haddr_i, `PCG_IDX_CTRL0)) begin
         next_rdata = clock_gate_ctrl_0 & `PCG_CTRL0_MASK;
      end else if (pcg_hit(haddr_i, `PCG_IDX_CTRL1)) begin
         next_rdata = clock_gate_ctrl_1 & `PCG_CTRL1_MASK;
      end else if (pcg_hit(haddr_i, `PCG_IDX_STAT0)) begin
         next_rdata = gate_q[7:0];
      end else if (pcg_hit(haddr_i, `PCG_IDX_STAT1)) begin
         next_rdata = {3'h0, gate_q[12:8]};
      end
   end

   // read data register; unmapped words read zero
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hrdata_o <= 32'h00000000;
      end else if (addr_take && !hwrite_i) begin
         hrdata_o <= {24'h000000, next_rdata};
      end
   end

   // wanted gate state, straight from the registers
   assign gate_req = pcg_gate_vec(clock_gate_ctrl_0, clock_gate_ctrl_1,
                                  timer2_async_select_i);

   // sleep flag moves on the falling edge too, so a deep sleep also
   // stops the gated clocks only while the source clock is low
   always @(negedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         run_q <= 1'b1;
      end else begin
         run_q <= clk_io_run_i;
      end
   end

   // converter: software disables it first, or a conversion is cut
   pcg_clk_gate gate_converter_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_CONVERTER]),
      .gclk_o (clk_converter_o),
      .held_o (gate_q[`PCG_P_CONVERTER])
   );

   // uart 0: a frame in flight is lost, software reinitialises it
   pcg_clk_gate gate_uart_0_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_UART_0]),
      .gclk_o (clk_uart_0_o),
      .held_o (gate_q[`PCG_P_UART_0])
   );

   // serial peripheral interface: reinitialised by software on release
   pcg_clk_gate gate_serial_periph_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_SERIAL]),
      .gclk_o (clk_serial_periph_o),
      .held_o (gate_q[`PCG_P_SERIAL])
   );

   // timer 1: counts on from where it stopped
   pcg_clk_gate gate_timer_1_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TIMER_1]),
      .gclk_o (clk_timer_1_o),
      .held_o (gate_q[`PCG_P_TIMER_1])
   );

   // timer 0: counts on from where it stopped
   pcg_clk_gate gate_timer_0_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TIMER_0]),
      .gclk_o (clk_timer_0_o),
      .held_o (gate_q[`PCG_P_TIMER_0])
   );

   // timer 2: the hold request is already dropped in async mode
   pcg_clk_gate gate_timer_2_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TIMER_2]),
      .gclk_o (clk_timer_2_o),
      .held_o (gate_q[`PCG_P_TIMER_2])
   );

   // two-wire interface: bus state may be stale once released
   pcg_clk_gate gate_two_wire_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TWO_WIRE]),
      .gclk_o (clk_two_wire_o),
      .held_o (gate_q[`PCG_P_TWO_WIRE])
   );

   // uart 1: reinitialised by software on release
   pcg_clk_gate gate_uart_1_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_UART_1]),
      .gclk_o (clk_uart_1_o),
      .held_o (gate_q[`PCG_P_UART_1])
   );

   // uart 2: reinitialised by software on release
   pcg_clk_gate gate_uart_2_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_UART_2]),
      .gclk_o (clk_uart_2_o),
      .held_o (gate_q[`PCG_P_UART_2])
   );

   // uart 3: reinitialised by software on release
   pcg_clk_gate gate_uart_3_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_UART_3]),
      .gclk_o (clk_uart_3_o),
      .held_o (gate_q[`PCG_P_UART_3])
   );

   // timer 3: counts on from where it stopped
   pcg_clk_gate gate_timer_3_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TIMER_3]),
      .gclk_o (clk_timer_3_o),
      .held_o (gate_q[`PCG_P_TIMER_3])
   );

   // timer 4: counts on from where it stopped
   pcg_clk_gate gate_timer_4_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TIMER_4]),
      .gclk_o (clk_timer_4_o),
      .held_o (gate_q[`PCG_P_TIMER_4])
   );

   // timer 5: counts on from where it stopped
   pcg_clk_gate gate_timer_5_u (
      .clk_i  (mclk_i),
      .rstn_i (rstn_i),
      .run_i  (run_q),
      .hold_i (gate_req[`PCG_P_TIMER_5]),
      .gclk_o (clk_timer_5_o),
      .held_o (gate_q[`PCG_P_TIMER_5])
   );

   // a frozen peripheral cannot take reads or writes; the block uses
   // the applied gate state so access and clock stop together
   assign periph_access_o = periph_access_i & ~gate_q;

endmodule

// glitch-free gate for one peripheral clock: the hold flop moves on the
// falling edge, so the and gate only ever sees a change in the low phase
module pcg_clk_gate (
   // source clock and reset
   input  wire clk_i,
   input  wire rstn_i,
   // sleep flag moved on the falling edge, wanted hold settled before it
   input  wire run_i,
   input  wire hold_i,
   // gated clock and the applied hold
   output wire gclk_o,
   output reg  held_o
);

   // hold flop on the falling edge; reset leaves the clock running
   always @(negedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         held_o <= 1'b0;
      end else begin
         held_o <= hold_i;
      end
   end

   // a held peripheral sees no edge, so its flops keep their state
   assign gclk_o = clk_i & run_i & ~held_o;

endmodule
`default_nettype wire

//--- tb/pcg_checker_assertions.sv
// checker: bus answer, read data hold and gated clock shape
// assumes it is bound to pcg_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pcg_checker (
   // clock, reset and bus
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        hsel_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic        hready_i,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic [31:0] hrdata_o,
   // system state, access strobes and clocks
   input wire logic        clk_io_run_i,
   input wire logic        timer2_async_select_i,
   input wire logic [12:0] periph_access_i,
   input wire logic [12:0] periph_access_o,
   input wire logic        clk_converter_o,
   input wire logic        clk_timer_2_o,
   input wire logic        clk_two_wire_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // sleep request as the falling-edge run flop sees it
   sequence sleep_seen;
      !clk_io_run_i;
   endsequence
   zero_wait_a: assert property (hreadyout_o == 1'h1)
      else $error("wait state inserted");
   resp_okay_a: assert property (hresp_o == 1'h0)
      else $error("response not okay");
   rdata_upper_a: assert property (hrdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   // only a read address phase may move the read data
   rdata_hold_a: assert property (!(hsel_i && htrans_i == 2'h2 && hready_i
      && !hwrite_i) |=> $stable(hrdata_o)) else $error("read data moved");
   reset_rdata_a: assert property ($rose(rstn_i) |-> hrdata_o == 32'h0)
      else $error("read data not cleared");
   access_block_a: assert property
      ((periph_access_o & ~periph_access_i) == 13'h0000)
      else $error("access strobe invented");
   // sampled just before the rise, a clean gate output is always low
   gate_glitch_a: assert property
      (!(clk_converter_o || clk_timer_2_o || clk_two_wire_o))
      else $error("gated clock high while source low");
   sleep_stop_a: assert property
      (@(negedge mclk_i) sleep_seen |=> !clk_two_wire_o && !clk_converter_o)
      else $error("clock runs in deep sleep");
   t2_async_run_a: assert property (@(negedge mclk_i)
      $past(timer2_async_select_i) && $past(clk_io_run_i) |-> clk_timer_2_o)
      else $error("asynchronous timer gated");
endmodule
bind pcg_top pcg_checker chk_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .hrdata_o(hrdata_o), .clk_io_run_i(clk_io_run_i),
   .timer2_async_select_i(timer2_async_select_i),
   .periph_access_i(periph_access_i), .periph_access_o(periph_access_o),
   .clk_converter_o(clk_converter_o), .clk_timer_2_o(clk_timer_2_o),
   .clk_two_wire_o(clk_two_wire_o));
`default_nettype wire

//--- tb/pcg_periph_model.sv
// peripherals behind the gates: one edge counter per gated clock
// assumes clocks arrive in the slot order of the gating block
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model (
   // reset and gated clocks
   input  wire logic             rstn_i,
   input  wire logic [12:0]      gclk_i,
   // peripheral state seen by the bench
   output wire logic [12:0][7:0] cnt_o
);
   // the counter is the state; a stopped clock freezes it in place
   for (genvar g = 0; g < 13; g++) begin : g_per
      logic [7:0] cnt_q;
      always @(posedge gclk_i[g] or negedge rstn_i) begin
         if (!rstn_i)
            cnt_q <= 8'h00;
         else
            cnt_q <= cnt_q + 8'h01;
      end
      assign cnt_o[g] = cnt_q;
   end
endmodule
`default_nettype wire

//--- tb/peripheral_clock_gating_tb_top.sv
// bench: register traffic over ahb-lite, access and clock freeze checks
// assumes pcg_top and the edge-counter peripheral model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   n_errors++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module peripheral_clock_gating_tb_top;
   logic             mclk_i = 0, rstn_i = 0, hsel_i = 0, hwrite_i = 0;
   logic             run = 1, t2a = 0;
   logic [31:0]      haddr_i = 0, hwdata_i = 0, rd, a, d;
   logic [1:0]       htrans_i = 0;
   logic [12:0]      acc = 13'h1FFF;
   wire logic        hrdy;
   wire logic [12:0] acc_o, gclk;
   logic [12:0][7:0] cnt;
   logic [7:0]       snap;
   int               n_errors = 0, samples_checked = 0, s;
   pcg_top dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata_i),
      .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(rd),
      .clk_io_run_i(run), .timer2_async_select_i(t2a),
      .periph_access_i(acc), .periph_access_o(acc_o),
      .clk_converter_o(gclk[0]), .clk_uart_0_o(gclk[1]),
      .clk_serial_periph_o(gclk[2]), .clk_timer_1_o(gclk[3]),
      .clk_timer_0_o(gclk[4]), .clk_timer_2_o(gclk[5]),
      .clk_two_wire_o(gclk[6]), .clk_uart_1_o(gclk[7]),
      .clk_uart_2_o(gclk[8]), .clk_uart_3_o(gclk[9]),
      .clk_timer_3_o(gclk[10]), .clk_timer_4_o(gclk[11]),
      .clk_timer_5_o(gclk[12]));
   pcg_periph_model per_u (.rstn_i(rstn_i), .gclk_i(gclk), .cnt_o(cnt));
   // 10 MHz system clock
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic summarize;
      if (n_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one single transfer; every wait is bounded by the ready count
   task automatic xfer(input logic w, input logic [31:0] ad, wd);
      int n;
      n = 0;
      @(posedge mclk_i); // requests always start just after an edge
      hsel_i <= 1'h1; haddr_i <= ad; htrans_i <= 2'h2; hwrite_i <= w;
      do begin @(posedge mclk_i); n++; end while (hrdy !== 1'h1 && n < 50);
      hsel_i <= 1'h0; htrans_i <= 2'h0; hwdata_i <= wd;
      do begin @(posedge mclk_i); n++; end while (hrdy !== 1'h1 && n < 50);
      if (n >= 50) begin
         n_errors++;
         summarize();
      end
   endtask
   task automatic rdc(input logic [31:0] ad, ex);
      xfer(1'h0, ad, 32'h0);
      `CHK(rd, ex)
   endtask
   initial begin
      repeat (20) @(posedge mclk_i);
      rstn_i <= 1'h1;
      @(posedge mclk_i);
      rdc(32'h190, 32'h0);
      rdc(32'h194, 32'h0);
      xfer(1'h1, 32'h190, 32'hFFFFFFFF);
      xfer(1'h1, 32'h194, 32'hFFFFFFFF);
      rdc(32'h190, 32'hEF);
      rdc(32'h194, 32'h3F);
      rdc(32'h198, 32'hFF);
      rdc(32'h19C, 32'h1F);
      `CHK(acc_o, 13'h0000)
      xfer(1'h1, 32'h190, 32'h0);
      xfer(1'h1, 32'h194, 32'h0);
      xfer(1'h1, 32'h4, 32'hFF);
      rdc(32'h4, 32'h0);
      // each slot alone: blocked, frozen, then resumed where it stopped
      for (s = 0; s < 13; s++) begin
         a = s < 7 ? 32'h190 : 32'h194;
         d = s < 4 ? 32'h1 << s : s < 7 ? 32'h1 << (s + 1) : 32'h1 << (s - 7);
         xfer(1'h1, a, d);
         repeat (2) @(posedge mclk_i);
         @(negedge mclk_i) snap = cnt[s];
         `CHK(acc_o, 13'h1FFF ^ (13'h1 << s))
         repeat (4) @(posedge mclk_i);
         @(negedge mclk_i) `CHK(cnt[s], snap)
         xfer(1'h1, a, 32'h0);
         repeat (2) @(posedge mclk_i);
         @(negedge mclk_i) `CHK(cnt[s], snap + 8'h02)
      end
      @(posedge mclk_i) t2a <= 1'h1;
      xfer(1'h1, 32'h190, 32'h40);
      rdc(32'h198, 32'h0);
      `CHK(acc_o, 13'h1FFF)
      t2a <= 1'h0;
      @(posedge mclk_i) `CHK(acc_o, 13'h1FDF)
      xfer(1'h1, 32'h190, 32'h0);
      run <= 1'h0;
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i) snap = cnt[0];
      repeat (4) @(posedge mclk_i);
      @(negedge mclk_i) `CHK(cnt[0], snap)
      @(posedge mclk_i) run <= 1'h1;
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i) `CHK(cnt[0], snap + 8'h02)
      summarize();
   end
endmodule
`default_nettype wire
